// ### rtl/sli_pkg.sv
// Purpose: Constants for the switch status indicator controller
// Assumes: 250 MHz system clock
// Notes:   Blink periods derived from rates in times per second
package sli_pkg;
   localparam int unsigned CLK_HZ         = 250_000_000;
   localparam int unsigned FAST_PER_SEC   = 4;
   localparam int unsigned SLOW_PER_SEC   = 2;
   localparam int unsigned SWEEP_STEP_MS  = 250;
   // Half periods in clock cycles
   localparam int unsigned FAST_HALF_CYC  = CLK_HZ / (2 * FAST_PER_SEC);
   localparam int unsigned SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_PER_SEC);
   localparam int unsigned SWEEP_STEP_CYC = (CLK_HZ / 1000) * SWEEP_STEP_MS;
   localparam int unsigned CNT_W          = 26;
   localparam int unsigned NUM_COPPER     = 6;
   localparam int unsigned NUM_FIBER      = 3;
   localparam int unsigned NUM_SYS_LAMPS  = 2;
   localparam logic [1:0]  SWEEP_LAST     = 2'h2;
   localparam logic [4:0]  IRQ_RESET      = 5'h00;
   // Register offsets and interrupt bit positions
   localparam logic [3:0]  ADDR_STATUS    = 4'h0;
   localparam logic [3:0]  ADDR_MASK      = 4'h4;
   localparam logic [3:0]  ADDR_LAMPS     = 4'h8;
   localparam int unsigned EV_MASTER_BLINK = 0;
   localparam int unsigned EV_CPLR_BLINK   = 1;
   localparam int unsigned EV_LOCATOR      = 2;
   localparam int unsigned EV_FILE_XFER    = 3;
   localparam int unsigned EV_PORT_DOWN    = 4;
   localparam int unsigned NUM_EV          = 5;
endpackage

// ### rtl/sli_status_indicator.sv
// Purpose: Drives front panel role and port lamps from switch status flags
// Assumes: Status flags come from logic on clk_sys
// Notes:   Lamp outputs are registered; one level interrupt output
// Notes on behaviour
// - Master lamp steady on for master, head or root; off otherwise.
// - Master lamp blinks 4/s after taking ring master on ring failure.
// - Master lamp blinks 4/s when chain head and chain failed.
// - Master lamp blinks 4/s when ring member and its ring port down.
// - Master lamp blinks 4/s when chain member/tail and head-end port down.
// - Coupler lamp steady green for coupling, dual homing or chain tail.
// - Coupler lamp blinks 4/s when chain tail and chain failed.
// - Coupler lamp blinks 4/s when chain member/head and tail-end port down.
// - Coupler lamp off when coupling, dual homing and tail role all disabled.
// - Locator blinks all system lamps green, amber, red together at 2/s.
// - File transfer sweeps system lamps through green, amber, red in turn.
// - Copper upper lamp green on at 100M link, blinks 4/s with traffic.
// - Copper lower lamp amber on at 10M link, blinks 4/s with traffic.
// - Port lamps off when port inactive or link down.
// - Fiber green lamp on at 100M, blinks 4/s with traffic.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module sli_status_indicator
   import sli_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  clkEn,
   input  wire logic                  ringMaster,
   input  wire logic                  ringMasterTakeover,
   input  wire logic                  ringMember,
   input  wire logic                  ringPortDown,
   input  wire logic                  chainHead,
   input  wire logic                  chainTail,
   input  wire logic                  chainMember,
   input  wire logic                  chainFailed,
   input  wire logic                  headPortDown,
   input  wire logic                  tailPortDown,
   input  wire logic                  rstpRoot,
   input  wire logic                  couplingEn,
   input  wire logic                  dualHomingEn,
   input  wire logic                  locatorActive,
   input  wire logic                  fileXferActive,
   input  wire logic [NUM_COPPER-1:0] cuLink,
   input  wire logic [NUM_COPPER-1:0] cuSpeed100,
   input  wire logic [NUM_COPPER-1:0] cuActivity,
   input  wire logic [NUM_FIBER-1:0]  fxLink,
   input  wire logic [NUM_FIBER-1:0]  fxActivity,
   input  wire logic [3:0]            regAddr,
   input  wire logic [31:0]           regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic [31:0]                regRdata,
   output logic                       irq,
   output logic                       masterLampGreen,
   output logic                       couplerLampGreen,
   output logic [NUM_SYS_LAMPS-1:0]   sysLampAmber,
   output logic [NUM_SYS_LAMPS-1:0]   sysLampRed,
   output logic [NUM_COPPER-1:0]      cuUpperGreen,
   output logic [NUM_COPPER-1:0]      cuLowerAmber,
   output logic [NUM_FIBER-1:0]       fxGreen
);

   logic [CNT_W-1:0]      fastCnt_ff;
   logic [CNT_W-1:0]      sweepCnt_ff;
   logic                  fastPh_ff;
   logic                  slowPh_ff;
   logic [1:0]            sweepIdx_ff;
   logic                  sweepOn_ff;
   logic [NUM_EV-1:0]     status_ff;
   logic [NUM_EV-1:0]     mask_ff;
   logic [NUM_EV-1:0]     evPrev_ff;
   logic [NUM_EV-1:0]     evNow;
   logic                  masterBlink;
   logic                  masterSteady;
   logic                  cplrBlink;
   logic                  cplrSteady;
   logic                  nxt_master;
   logic                  nxt_cplr;
   logic                  nxt_green;
   logic                  nxt_amber;
   logic                  nxt_red;
   logic [NUM_COPPER-1:0] nxt_cuUp;
   logic [NUM_COPPER-1:0] nxt_cuLo;
   logic [NUM_FIBER-1:0]  nxt_fx;
   logic [NUM_SYS_LAMPS-1:0] lampsVec;

   // Lamp state for a link with optional traffic blink
   function automatic logic linkLamp(input logic up, input logic act, input logic ph);
      linkLamp = up & (~act | ph);
   endfunction

   // Single free divider: fast phase toggles, slow phase toggles every second fast toggle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fastCnt_ff <= '0;
         fastPh_ff  <= 1'b0;
         slowPh_ff  <= 1'b0;
      end else if (clkEn) begin
         if (fastCnt_ff == CNT_W'(FAST_HALF_CYC - 1)) begin
            fastCnt_ff <= '0;
            fastPh_ff  <= ~fastPh_ff;
            if (fastPh_ff) begin
               slowPh_ff <= ~slowPh_ff;
            end
         end else begin
            fastCnt_ff <= fastCnt_ff + CNT_W'(1);
         end
      end
   end

   // File transfer sweep: each colour on then off, in turn
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sweepCnt_ff <= '0;
         sweepIdx_ff <= 2'h0;
         sweepOn_ff  <= 1'b1;
      end else if (clkEn) begin
         if (!fileXferActive) begin
            sweepCnt_ff <= '0;
            sweepIdx_ff <= 2'h0;
            sweepOn_ff  <= 1'b1;
         end else if (sweepCnt_ff == CNT_W'(SWEEP_STEP_CYC - 1)) begin
            sweepCnt_ff <= '0;
            sweepOn_ff  <= ~sweepOn_ff;
            if (!sweepOn_ff) begin
               sweepIdx_ff <= (sweepIdx_ff == SWEEP_LAST) ? 2'h0 : sweepIdx_ff + 2'h1;
            end
         end else begin
            sweepCnt_ff <= sweepCnt_ff + CNT_W'(1);
         end
      end
   end

   // Role lamp decisions
   always_comb begin
      masterBlink  = ringMasterTakeover
                   | (chainHead & chainFailed)
                   | (ringMember & ringPortDown)
                   | ((chainMember | chainTail) & headPortDown);
      masterSteady = ringMaster | chainHead | rstpRoot;
      cplrBlink    = (chainTail & chainFailed)
                   | ((chainMember | chainHead) & tailPortDown);
      cplrSteady   = couplingEn | dualHomingEn | chainTail;
   end

   // Next lamp values with overlay priority
   always_comb begin
      nxt_master = masterBlink ? fastPh_ff : masterSteady;
      nxt_cplr   = cplrBlink ? fastPh_ff : cplrSteady;
      nxt_amber  = 1'b0;
      nxt_red    = 1'b0;
      nxt_green  = 1'b0;
      if (locatorActive) begin
         nxt_green  = slowPh_ff;
         nxt_amber  = slowPh_ff;
         nxt_red    = slowPh_ff;
         nxt_master = nxt_green;
         nxt_cplr   = nxt_green;
      end else if (fileXferActive) begin
         nxt_green  = sweepOn_ff & (sweepIdx_ff == 2'h0);
         nxt_amber  = sweepOn_ff & (sweepIdx_ff == 2'h1);
         nxt_red    = sweepOn_ff & (sweepIdx_ff == SWEEP_LAST);
         nxt_master = nxt_green;
         nxt_cplr   = nxt_green;
      end
      for (int i = 0; i < NUM_COPPER; i++) begin
         nxt_cuUp[i] = linkLamp(cuLink[i] & cuSpeed100[i],
                                cuActivity[i], fastPh_ff);
         nxt_cuLo[i] = linkLamp(cuLink[i] & ~cuSpeed100[i],
                                cuActivity[i], fastPh_ff);
      end
      for (int i = 0; i < NUM_FIBER; i++) begin
         nxt_fx[i] = linkLamp(fxLink[i], fxActivity[i], fastPh_ff);
      end
   end

   // Registered lamp outputs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         masterLampGreen  <= 1'b0;
         couplerLampGreen <= 1'b0;
         sysLampAmber     <= '0;
         sysLampRed       <= '0;
         cuUpperGreen     <= '0;
         cuLowerAmber     <= '0;
         fxGreen          <= '0;
      end else if (clkEn) begin
         masterLampGreen  <= nxt_master;
         couplerLampGreen <= nxt_cplr;
         sysLampAmber     <= {NUM_SYS_LAMPS{nxt_amber}};
         sysLampRed       <= {NUM_SYS_LAMPS{nxt_red}};
         cuUpperGreen     <= nxt_cuUp;
         cuLowerAmber     <= nxt_cuLo;
         fxGreen          <= nxt_fx;
      end
   end

   // Event sources for sticky status
   always_comb begin
      evNow                  = '0;
      evNow[EV_MASTER_BLINK] = masterBlink;
      evNow[EV_CPLR_BLINK]   = cplrBlink;
      evNow[EV_LOCATOR]      = locatorActive;
      evNow[EV_FILE_XFER]    = fileXferActive;
      evNow[EV_PORT_DOWN]    = ringPortDown | headPortDown | tailPortDown;
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         status_ff <= IRQ_RESET;
         evPrev_ff <= IRQ_RESET;
      end else if (clkEn) begin
         evPrev_ff <= evNow;
         status_ff <= (status_ff & ~((regWr && regAddr == ADDR_STATUS) ?
                       regWdata[NUM_EV-1:0] : IRQ_RESET)) | (evNow & ~evPrev_ff);
      end
   end

   // Mask register
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mask_ff <= IRQ_RESET;
      end else if (clkEn && regWr && regAddr == ADDR_MASK) begin
         mask_ff <= regWdata[NUM_EV-1:0];
      end
   end

   assign lampsVec = {masterLampGreen, couplerLampGreen};

   // Read data and interrupt
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         regRdata <= '0;
         irq      <= 1'b0;
      end else if (clkEn) begin
         irq      <= |(status_ff & mask_ff);
         regRdata <= '0;
         if (regRd) begin
            unique case (regAddr)
               ADDR_STATUS: regRdata <= {27'h000_0000, status_ff};
               ADDR_MASK:   regRdata <= {27'h000_0000, mask_ff};
               ADDR_LAMPS:  regRdata <= {30'h0000_0000, lampsVec};
               default:     regRdata <= '0;
            endcase
         end
      end
   end

endmodule

// ### tb/sli_panel_model.sv
// Purpose: Front panel lamp model
// Assumes: Lamp outputs are active high
// Notes:   Counts the lamps an operator would see lit
`timescale 1ns/10ps
module sli_panel_model
   import sli_pkg::*;
(
   input wire logic                     masterLampGreen, couplerLampGreen,
   input wire logic [NUM_SYS_LAMPS-1:0] sysLampAmber, sysLampRed,
   input wire logic [NUM_COPPER-1:0]    cuUpperGreen, cuLowerAmber,
   input wire logic [NUM_FIBER-1:0]     fxGreen,
   output logic [4:0]                   litCount
);
   assign litCount = 5'($countones({masterLampGreen, couplerLampGreen, sysLampAmber,
      sysLampRed, cuUpperGreen, cuLowerAmber, fxGreen}));
endmodule

// ### tb/sli_props.sv
// Purpose: Port assertions for the status indicator
// Assumes: Bound to sli_status_indicator, clkEn mostly high
// Notes:   Role lamp checks skip locator and file patterns
`timescale 1ns/10ps
module sli_props
   import sli_pkg::*;
(
   input wire logic clk_sys, srst, clkEn, regRd, masterLampGreen, couplerLampGreen,
   input wire logic ringMaster, ringMasterTakeover, ringMember, ringPortDown, chainHead,
   input wire logic chainTail, chainMember, chainFailed, headPortDown, tailPortDown,
   input wire logic rstpRoot, couplingEn, dualHomingEn, locatorActive, fileXferActive,
   input wire logic [NUM_COPPER-1:0]    cuLink, cuSpeed100, cuActivity, cuUpperGreen, cuLowerAmber,
   input wire logic [NUM_FIBER-1:0]     fxLink, fxActivity, fxGreen,
   input wire logic [NUM_SYS_LAMPS-1:0] sysLampAmber, sysLampRed,
   input wire logic [31:0]              regRdata
);
   logic mOn, mBlink, cOn, cBlink, quiet;
   assign mOn = ringMaster | chainHead | rstpRoot;
   assign mBlink = ringMasterTakeover | (chainHead & chainFailed) | (ringMember & ringPortDown)
      | ((chainMember | chainTail) & headPortDown);
   assign cOn = couplingEn | dualHomingEn | chainTail;
   assign cBlink = (chainTail & chainFailed) | ((chainMember | chainHead) & tailPortDown);
   assign quiet = clkEn & !locatorActive & !fileXferActive;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_master_steady: assert property (quiet && !mBlink |=> masterLampGreen == $past(mOn))
      else $error("master lamp level wrong");
   a_coupler_steady: assert property (quiet && !cBlink |=> couplerLampGreen == $past(cOn))
      else $error("coupler lamp level wrong");
   a_upper_port: assert property (clkEn |=> (cuUpperGreen & ~$past(cuLink & cuSpeed100)) == '0
      && ((cuUpperGreen ^ $past(cuLink & cuSpeed100)) & ~$past(cuActivity)) == '0)
      else $error("copper upper lamp wrong");
   a_lower_port: assert property (clkEn |=> (cuLowerAmber & ~$past(cuLink & ~cuSpeed100)) == '0
      && ((cuLowerAmber ^ $past(cuLink & ~cuSpeed100)) & ~$past(cuActivity)) == '0)
      else $error("copper lower lamp wrong");
   a_fiber_port: assert property (clkEn |=> (fxGreen & ~$past(fxLink)) == '0
      && ((fxGreen ^ $past(fxLink)) & ~$past(fxActivity)) == '0)
      else $error("fiber lamp wrong");
   a_locator_together: assert property (clkEn && locatorActive |=>
      sysLampAmber == {NUM_SYS_LAMPS{masterLampGreen}} && sysLampRed == sysLampAmber
      && couplerLampGreen == masterLampGreen) else $error("locator lamps not together");
   a_sweep_single: assert property (clkEn && fileXferActive && !locatorActive |=>
      $countones({masterLampGreen, sysLampAmber[0], sysLampRed[0]}) <= 1
      && couplerLampGreen == masterLampGreen) else $error("sweep shows two colours");
   a_normal_dark: assert property (quiet |=> sysLampAmber == '0 && sysLampRed == '0)
      else $error("amber or red lit without pattern");
   a_blink_phase: assert property (quiet && mBlink && cBlink |=>
      masterLampGreen == couplerLampGreen) else $error("role lamps blink out of phase");
   a_read_idle: assert property (clkEn && !regRd |=> regRdata == '0)
      else $error("read data without read");
endmodule
bind sli_status_indicator sli_props u_props (.*);

// ### tb/sli_status_indicator_tb.sv
// Purpose: Self-checking bench for the status indicator
// Assumes: Blink phases stay at zero for the whole run
// Notes:   Blinking lamps show dark; events prove the blink cases
`timescale 1ns/10ps
module sli_status_indicator_tb
   import sli_pkg::*;
();
   logic clk_sys = 0, srst = 1, clkEn = 1, regWr = 0, regRd = 0, irq;
   logic locatorActive = 0, fileXferActive = 0, masterLampGreen, couplerLampGreen;
   logic ringMaster, ringMasterTakeover, ringMember, ringPortDown, chainHead, chainTail;
   logic chainMember, chainFailed, headPortDown, tailPortDown, rstpRoot, couplingEn, dualHomingEn;
   logic [12:0] roles = '0;
   logic [NUM_COPPER-1:0] cuLink = '0, cuSpeed100 = '0, cuActivity = '0, cuUpperGreen, cuLowerAmber;
   logic [NUM_FIBER-1:0] fxLink = '0, fxActivity = '0, fxGreen;
   logic [NUM_SYS_LAMPS-1:0] sysLampAmber, sysLampRed;
   logic [3:0] regAddr = '0;
   logic [31:0] regWdata = '0, regRdata, rv;
   logic [4:0] litCount;
   int errors = 0, n_checks = 0;
   localparam logic [12:0] CASES [14] = '{13'h1000, 13'h0100, 13'h0004, 13'h1800, 13'h0120,
      13'h0600, 13'h0050, 13'h0002, 13'h0001, 13'h0080, 13'h00A0, 13'h0108, 13'h00B0,
      13'h0000};
   localparam logic [3:0] EXP [14] = '{4'h8, 4'h8, 4'h8, 4'h1, 4'h1, 4'h1, 4'h1, 4'h4, 4'h4,
      4'h4, 4'h2, 4'hA, 4'h3, 4'h0};
   assign {ringMaster, ringMasterTakeover, ringMember, ringPortDown, chainHead, chainTail,
      chainMember, chainFailed, headPortDown, tailPortDown, rstpRoot, couplingEn,
      dualHomingEn} = roles;
   always #2 clk_sys = ~clk_sys;
   sli_status_indicator dut (.*);
   sli_panel_model panel (.*);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys) {regWr, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clk_sys) regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys) {regRd, regAddr} <= {1'b1, a};
      @(posedge clk_sys) regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      $display("FAIL watchdog expected done seen timeout");
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      settle();
      chk("lamps after reset", litCount, 5'h00);
      rd(ADDR_MASK, rv);
      chk("mask reset", rv, 32'h0000_0000);
      wr(ADDR_MASK, 32'h0000_0003);
      @(posedge clk_sys) clkEn <= 1'b0;
      wr(ADDR_MASK, 32'h0000_001F);
      @(posedge clk_sys) clkEn <= 1'b1;
      rd(ADDR_MASK, rv);
      chk("mask", rv, 32'h0000_0003);
      rd(4'hC, rv);
      chk("unmapped", rv, 32'h0000_0000);
      $display("test registers done");
      for (int i = 0; i < 14; i++) begin
         @(posedge clk_sys) roles <= CASES[i];
         settle();
         chk("master lamp", masterLampGreen, EXP[i][3]);
         chk("coupler lamp", couplerLampGreen, EXP[i][2]);
         rd(ADDR_STATUS, rv);
         chk("role events", rv[1:0], EXP[i][1:0]);
         chk("irq", irq, |EXP[i][1:0]);
         wr(ADDR_STATUS, 32'h0000_001F);
         @(posedge clk_sys) roles <= '0;
         settle();
         chk("irq cleared", irq, 1'h0);
      end
      $display("test roles done");
      @(posedge clk_sys) {roles, cuLink, cuSpeed100, cuActivity, fxLink, fxActivity} <=
         {13'h1002, 6'h2F, 6'h0F, 6'h01, 3'h3, 3'h2};
      settle();
      chk("copper upper", cuUpperGreen, 6'h0E);
      chk("copper lower", cuLowerAmber, 6'h20);
      chk("fiber", fxGreen, 3'h1);
      rd(ADDR_LAMPS, rv);
      chk("lamp readback", rv, 32'h0000_0003);
      wr(ADDR_LAMPS, 32'h0000_0000);
      rd(ADDR_LAMPS, rv);
      chk("lamp read only", rv, 32'h0000_0003);
      $display("test ports done");
      wr(ADDR_STATUS, 32'h0000_001F);
      @(posedge clk_sys) locatorActive <= 1'b1;
      settle();
      chk("locator lamps", {masterLampGreen, couplerLampGreen, sysLampAmber, sysLampRed},
         6'h00);
      rd(ADDR_STATUS, rv);
      chk("locator event", rv[2], 1'h1);
      chk("masked irq", irq, 1'h0);
      wr(ADDR_MASK, 32'h0000_0004);
      settle();
      chk("unmasked irq", irq, 1'h1);
      @(posedge clk_sys) {locatorActive, fileXferActive, roles} <= {1'b0, 1'b1, 13'h0000};
      settle();
      chk("sweep first step", {masterLampGreen, couplerLampGreen, sysLampAmber, sysLampRed},
         6'h30);
      rd(ADDR_STATUS, rv);
      chk("file event", rv[3], 1'h1);
      @(posedge clk_sys) fileXferActive <= 1'b0;
      settle();
      chk("lamps after patterns", litCount, 5'h05);
      $display("test patterns done");
      report_and_stop();
   end
endmodule
